// *** rtl/pwm_timer_output_event_ctrl.sv ***
// Output, event, fault, interrupt and protection logic of the timer.
// Assumes the counter core runs on I_REF_CLK and hands in phase, match
// pulses and raw waveform levels; event inputs arrive asynchronously.
`timescale 1ns/100ps
`include "pwm_out_map.svh"
module pwm_timer_output_event_ctrl
  import pwm_out_pkg::*;
#(
  parameter int DLY_W = 8
) (
  input wire logic I_REF_CLK,
  input wire logic I_RST,
  input wire logic I_CLK_EN,
  input wire logic I_HSEL,
  input wire logic [31:0] I_HADDR,
  input wire logic [1:0] I_HTRANS,
  input wire logic I_HWRITE,
  input wire logic [2:0] I_HSIZE,
  input wire logic [31:0] I_HWDATA,
  input wire logic I_HREADY,
  output logic [31:0] O_HRDATA,
  output logic O_HREADYOUT,
  output logic O_HRESP,
  input wire logic I_WAVE_FIRST,
  input wire logic I_WAVE_SECOND,
  input wire logic [1:0] I_PHASE,
  input wire logic I_ONE_RAMP,
  input wire logic [3:0] I_MATCH,
  input wire logic I_CYCLE_DONE,
  input wire logic [1:0] I_EVENT_IN,
  input wire logic I_SLEEP_STOP,
  input wire logic I_DBG_HALT,
  output logic [3:0] O_WAVE,
  output logic [3:0] O_WAVE_OE_N,
  output logic [2:0] O_MATCH_EVENT,
  output logic O_PROG_EVENT,
  output logic [1:0] O_FAULT,
  output logic [1:0] O_CAPTURE,
  output logic O_IRQ_OVF,
  output logic O_IRQ_TRIG
);

  // ----------------------------------------------------------------
  // Register bus
  // ----------------------------------------------------------------
  logic [7:0] ctrl_c;
  logic [7:0] ctrl_d;
  logic [7:0] ev_ctrl [2];
  logic [7:0] int_en;
  logic [7:0] int_flags;
  logic [3:0] input_mode [2];
  fault_ctrl_t fault_ctrl;
  dly_ctrl_t dly_ctrl;
  logic [DLY_W-1:0] dly_val;
  logic [7:0] dbg_ctrl;
  logic [2:0] key_win;
  logic wr_pend;
  logic [7:0] wr_idx;
  logic [7:0] next_rdata;
  logic [7:0] addr_idx;
  logic bus_req;
  logic wr_now;
  logic [7:0] wdata;

  assign addr_idx = I_HADDR[9:2];
  assign bus_req = I_HSEL && I_HREADY && I_HTRANS[1];
  assign wr_now = wr_pend;
  assign wdata = I_HWDATA[7:0];

  // Address phase capture; every transfer completes without wait
  always_ff @(posedge I_REF_CLK or posedge I_RST) begin
    if (I_RST) begin
      wr_pend <= 1'b0;
      wr_idx <= 8'h00;
    end else if (I_CLK_EN) begin
      wr_pend <= bus_req && I_HWRITE;
      wr_idx <= addr_idx;
    end
  end

  // Read mux, unmapped words read as zero
  always_comb begin
    next_rdata = 8'h00;
    case (addr_idx)
      `IDX_CONTROL_REG_C: next_rdata = ctrl_c;
      `IDX_CONTROL_REG_D: next_rdata = ctrl_d;
      `IDX_EVCTRLA: next_rdata = ev_ctrl[0];
      `IDX_EVCTRLB: next_rdata = ev_ctrl[1];
      `IDX_INTEN: next_rdata = int_en;
      `IDX_INTERRUPT_FLAG_REG: next_rdata = int_flags;
      `IDX_INPUTA: next_rdata = {4'h0, input_mode[0]};
      `IDX_INPUTB: next_rdata = {4'h0, input_mode[1]};
      `IDX_FAULT_CONTROL_REG: next_rdata = fault_ctrl;
      `IDX_DELAY_CONTROL_REG: next_rdata = dly_ctrl;
      `IDX_DELAY_VALUE_REG: next_rdata = 8'(dly_val);
      `IDX_DEBUG_CONTROL_REG: next_rdata = dbg_ctrl;
      default: next_rdata = 8'h00;
    endcase
  end

  // Read data registered so it stands through the data phase
  always_ff @(posedge I_REF_CLK or posedge I_RST) begin
    if (I_RST) begin
      O_HRDATA <= 32'h0000_0000;
      O_HREADYOUT <= 1'b0;
      O_HRESP <= 1'b0;
    end else if (I_CLK_EN) begin
      O_HREADYOUT <= 1'b1;
      O_HRESP <= 1'b0;
      if (bus_req && !I_HWRITE) begin
        O_HRDATA <= {24'h00_0000, next_rdata};
      end
    end
  end

  // Plain control registers
  always_ff @(posedge I_REF_CLK or posedge I_RST) begin
    if (I_RST) begin
      ctrl_c <= `RST_BYTE;
      ctrl_d <= `RST_BYTE;
      ev_ctrl[0] <= `RST_BYTE;
      ev_ctrl[1] <= `RST_BYTE;
      int_en <= `RST_BYTE;
      input_mode[0] <= 4'h0;
      input_mode[1] <= 4'h0;
      dly_ctrl <= `RST_BYTE;
      dly_val <= '0;
      dbg_ctrl <= `RST_BYTE;
    end else if (I_CLK_EN && wr_now) begin
      case (wr_idx)
        `IDX_CONTROL_REG_C: ctrl_c <= wdata;
        `IDX_CONTROL_REG_D: ctrl_d <= wdata;
        `IDX_EVCTRLA: ev_ctrl[0] <= wdata;
        `IDX_EVCTRLB: ev_ctrl[1] <= wdata;
        `IDX_INTEN: int_en <= wdata & 8'h0D;
        `IDX_INPUTA: input_mode[0] <= wdata[3:0];
        `IDX_INPUTB: input_mode[1] <= wdata[3:0];
        `IDX_DELAY_CONTROL_REG: dly_ctrl <= wdata & 8'h3F;
        `IDX_DELAY_VALUE_REG: dly_val <= wdata[DLY_W-1:0];
        `IDX_DEBUG_CONTROL_REG: dbg_ctrl <= wdata & 8'h05;
        default: ;
      endcase
    end
  end

  // Key window counts bus transfers as a stand-in for instructions
  always_ff @(posedge I_REF_CLK or posedge I_RST) begin
    if (I_RST) begin
      key_win <= 3'h0;
    end else if (I_CLK_EN) begin
      if (wr_now && wr_idx == `IDX_KEY && wdata == `IO_KEY) begin
        key_win <= `KEY_WINDOW;
      end else if (key_win != 3'h0 && bus_req) begin
        key_win <= key_win - 3'h1;
      end
    end
  end

  // Protected fault control; unkeyed writes are dropped silently
  always_ff @(posedge I_REF_CLK or posedge I_RST) begin
    if (I_RST) begin
      fault_ctrl <= `RST_BYTE;
    end else if (I_CLK_EN && wr_now && wr_idx == `IDX_FAULT_CONTROL_REG &&
                 key_win != 3'h0) begin
      fault_ctrl <= wdata;
    end
  end

  // ----------------------------------------------------------------
  // Run control
  // ----------------------------------------------------------------
  logic run;
  logic dbg_fault;
  assign run = I_CLK_EN && !I_SLEEP_STOP &&
               (!I_DBG_HALT || dbg_ctrl[`B_DEBUG_RUN_BIT]);
  assign dbg_fault = I_DBG_HALT && dbg_ctrl[`B_DEBUG_FAULT_BIT];

  // ----------------------------------------------------------------
  // Event inputs
  // ----------------------------------------------------------------
  logic [1:0] ev_s1;
  logic [1:0] ev_s2;
  logic [1:0] ev_act;
  logic [1:0] ev_prev;
  logic [1:0] ev_rise;
  logic [1:0] ev_hit;
  logic [1:0] fault_hit;
  logic [1:0] mode_both;

  // Two flops per pin before any logic looks at the level
  always_ff @(posedge I_REF_CLK or posedge I_RST) begin
    if (I_RST) begin
      ev_s1 <= 2'b00;
      ev_s2 <= 2'b00;
    end else if (I_CLK_EN) begin
      ev_s1 <= I_EVENT_IN;
      ev_s2 <= ev_s1;
    end
  end

  genvar c;
  generate
    for (c = 0; c < 2; c++) begin : g_chan
      logic edge_mode;
      assign ev_act[c] = ev_ctrl[c][`B_EDGE] ? ev_s2[c] : !ev_s2[c];
      assign ev_rise[c] = ev_act[c] && !ev_prev[c];
      assign edge_mode = input_mode[c] == `MODE_EDGE_LO ||
                         input_mode[c] == `MODE_EDGE_HI;
      assign ev_hit[c] = edge_mode ? ev_rise[c] : ev_act[c];
      assign fault_hit[c] = (input_mode[c] != 4'h0 && ev_hit[c]) ||
                            dbg_fault;
      assign mode_both[c] = input_mode[c] <= `MODE_BOTH_HI;
    end
  endgenerate

  // Edge history, fault level to the core and capture strobes
  always_ff @(posedge I_REF_CLK or posedge I_RST) begin
    if (I_RST) begin
      // Default polarity makes idle-low pins active: no false edge on release
      ev_prev <= 2'b11;
      O_FAULT <= 2'b00;
      O_CAPTURE <= 2'b00;
    end else if (I_CLK_EN) begin
      ev_prev <= ev_act;
      O_FAULT <= fault_hit;
      // Capture and the input mode act on the same event
      O_CAPTURE[0] <= run && ev_rise[0] &&
                      ev_ctrl[0][`B_ACTION];
      O_CAPTURE[1] <= run && ev_rise[1] &&
                      ev_ctrl[1][`B_ACTION];
    end
  end

  // ----------------------------------------------------------------
  // Waveform outputs
  // ----------------------------------------------------------------
  logic [1:0] ov_idx_a;
  logic [1:0] ov_idx_b;
  logic [1:0] prim;
  logic [1:0] prim_fault;
  logic [3:0] src;

  // In single ramp each output looks only at its own dead/on pair
  assign ov_idx_a = I_ONE_RAMP ? {1'b0, I_PHASE[0]} : I_PHASE;
  assign ov_idx_b = I_ONE_RAMP ? {1'b1, I_PHASE[0]} : I_PHASE;
  assign prim[0] = ctrl_c[`B_OVR] ? ctrl_d[ov_idx_a] :
                   I_WAVE_FIRST;
  assign prim[1] = ctrl_c[`B_OVR] ? ctrl_d[3'd4 + 3'(ov_idx_b)] :
                   I_WAVE_SECOND;
  // Modes 1..7 on either channel stop both outputs
  assign prim_fault[0] = fault_hit[0] || (fault_hit[1] && mode_both[1]);
  assign prim_fault[1] = fault_hit[1] || (fault_hit[0] && mode_both[0]);
  assign src = {ctrl_c[`B_SEL_D], ctrl_c[`B_SEL_C], 2'b10};

  genvar o;
  generate
    for (o = 0; o < 4; o++) begin : g_out
      // Fault value wins over the waveform while the fault stands
      always_ff @(posedge I_REF_CLK or posedge I_RST) begin
        if (I_RST) begin
          O_WAVE[o] <= 1'b0;
          O_WAVE_OE_N[o] <= 1'b1;
        end else if (I_CLK_EN) begin
          O_WAVE_OE_N[o] <= !fault_ctrl.en[o];
          if (prim_fault[src[o]] && fault_ctrl.en[o]) begin
            O_WAVE[o] <= fault_ctrl.val[o];
          end else if (run) begin
            O_WAVE[o] <= prim[src[o]];
          end
        end
      end
    end
  endgenerate

  // ----------------------------------------------------------------
  // Match strobes and programmable event
  // ----------------------------------------------------------------
  dly_state_t dly_state;
  logic [2:0] presc_cnt;
  logic [2:0] presc_max;
  logic [DLY_W-1:0] dly_cnt;
  logic dly_trig;
  logic presc_tick;

  assign dly_trig = I_MATCH[dly_ctrl.trig];
  assign presc_max = 3'((4'h1 << dly_ctrl.presc) - 4'h1);
  assign presc_tick = presc_cnt == presc_max;

  // Strobes from second clear, first set and second set matches
  always_ff @(posedge I_REF_CLK or posedge I_RST) begin
    if (I_RST) begin
      O_MATCH_EVENT <= 3'b000;
    end else if (I_CLK_EN) begin
      O_MATCH_EVENT <= run ? {I_MATCH[2], I_MATCH[0], I_MATCH[3]} :
                       3'b000;
    end
  end

  // Delay engine shared with blanking; blanking bypasses the count
  always_ff @(posedge I_REF_CLK or posedge I_RST) begin
    if (I_RST) begin
      dly_state <= DLY_IDLE;
      presc_cnt <= 3'h0;
      dly_cnt <= '0;
      O_PROG_EVENT <= 1'b0;
    end else if (I_CLK_EN) begin
      O_PROG_EVENT <= 1'b0;
      if (run) begin
        case (dly_state)
          DLY_IDLE: begin
            presc_cnt <= 3'h0;
            dly_cnt <= '0;
            if (dly_trig && dly_ctrl.sel == `DLY_BLANK) begin
              O_PROG_EVENT <= 1'b1;
            end else if (dly_trig && dly_ctrl.sel == `DLY_EVENT) begin
              dly_state <= DLY_RUN;
            end
          end
          DLY_RUN: begin
            if (dly_cnt == dly_val) begin
              O_PROG_EVENT <= 1'b1;
              dly_state <= DLY_IDLE;
            end else if (presc_tick) begin
              presc_cnt <= 3'h0;
              dly_cnt <= dly_cnt + DLY_W'(1);
            end else begin
              presc_cnt <= presc_cnt + 3'h1;
            end
          end
          default: dly_state <= DLY_IDLE;
        endcase
      end
    end
  end

  // ----------------------------------------------------------------
  // Interrupt flags and requests
  // ----------------------------------------------------------------
  logic [7:0] flag_set;
  logic [7:0] flag_clr;
  assign flag_set = {4'h0, run && ev_rise[1], run && ev_rise[0],
                     1'b0, run && I_CYCLE_DONE};
  assign flag_clr = (wr_now && wr_idx == `IDX_INTERRUPT_FLAG_REG) ?
                    (wdata & 8'h0D) : 8'h00;

  // A set arriving with a clear is kept
  always_ff @(posedge I_REF_CLK or posedge I_RST) begin
    if (I_RST) begin
      int_flags <= `RST_BYTE;
    end else if (I_CLK_EN) begin
      int_flags <= (int_flags & ~flag_clr) | flag_set;
    end
  end

  // Requests stand while the flag and its enable bit are both set
  always_ff @(posedge I_REF_CLK or posedge I_RST) begin
    if (I_RST) begin
      O_IRQ_OVF <= 1'b0;
      O_IRQ_TRIG <= 1'b0;
    end else if (I_CLK_EN) begin
      O_IRQ_OVF <= int_flags[`B_OVF] && int_en[`B_OVF];
      O_IRQ_TRIG <= (int_flags[`B_TRIGGER_FLAG_FIRST] && int_en[`B_TRIGGER_FLAG_FIRST]) ||
                    (int_flags[`B_TRIGGER_FLAG_SECOND] && int_en[`B_TRIGGER_FLAG_SECOND]);
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  sequence keyed_s;
    I_CLK_EN && wr_now && wr_idx == `IDX_KEY && wdata == `IO_KEY;
  endsequence

  oe_follows_en_a: assert property (
    @(posedge I_REF_CLK) disable iff (I_RST)
    I_CLK_EN |=> O_WAVE_OE_N == ~$past(fault_ctrl.en))
    else $error("pin enable does not follow enable bits");

  fault_value_a: assert property (
    @(posedge I_REF_CLK) disable iff (I_RST)
    I_CLK_EN && fault_ctrl.en[0] && prim_fault[0] |=>
    O_WAVE[0] == $past(fault_ctrl.val[0]))
    else $error("faulted output not at fault value");

  aux_route_a: assert property (
    @(posedge I_REF_CLK) disable iff (I_RST)
    run && !(prim_fault[ctrl_c[`B_SEL_C]] && fault_ctrl.en[2]) |=>
    O_WAVE[2] == $past(prim[ctrl_c[`B_SEL_C]]))
    else $error("aux output not following selected output");

  override_val_a: assert property (
    @(posedge I_REF_CLK) disable iff (I_RST)
    run && ctrl_c[`B_OVR] && !I_ONE_RAMP &&
    !(prim_fault[0] && fault_ctrl.en[0]) |=>
    O_WAVE[0] == $past(ctrl_d[I_PHASE]))
    else $error("override value not applied");

  match_strobe_a: assert property (
    @(posedge I_REF_CLK) disable iff (I_RST)
    run && I_MATCH[3] |=> O_MATCH_EVENT[0] ##1 (!O_MATCH_EVENT[0] ||
    $past(I_MATCH[3])))
    else $error("match strobe wrong");

  prog_single_a: assert property (
    @(posedge I_REF_CLK) disable iff (I_RST)
    O_PROG_EVENT && dly_ctrl.sel == `DLY_EVENT |=> !O_PROG_EVENT)
    else $error("programmable event longer than one cycle");

  delay_zero_a: assert property (
    @(posedge I_REF_CLK) disable iff (I_RST)
    run && dly_state == DLY_IDLE && dly_trig &&
    dly_ctrl.sel == `DLY_EVENT && dly_val == '0 ##1 run |=>
    O_PROG_EVENT)
    else $error("zero delay event late");

  blank_now_a: assert property (
    @(posedge I_REF_CLK) disable iff (I_RST)
    run && dly_state == DLY_IDLE && dly_trig &&
    dly_ctrl.sel == `DLY_BLANK |=> O_PROG_EVENT)
    else $error("blanking event was delayed");

  ovf_flag_a: assert property (
    @(posedge I_REF_CLK) disable iff (I_RST)
    run && I_CYCLE_DONE |=> int_flags[`B_OVF] ##1
    (I_CLK_EN ? O_IRQ_OVF == $past(int_en[`B_OVF]) : 1'b1))
    else $error("overflow flag or request missing");

  irq_hold_a: assert property (
    @(posedge I_REF_CLK) disable iff (I_RST)
    I_CLK_EN && int_flags[`B_OVF] && int_en[`B_OVF] |=> O_IRQ_OVF)
    else $error("overflow request dropped while flag set");

  dbg_fault_a: assert property (
    @(posedge I_REF_CLK) disable iff (I_RST)
    I_CLK_EN && dbg_fault |=> O_FAULT == 2'b11)
    else $error("debug break fault not on both channels");

  key_guard_a: assert property (
    @(posedge I_REF_CLK) disable iff (I_RST)
    I_CLK_EN && key_win == 3'h0 |=> $stable(fault_ctrl))
    else $error("fault control changed without key");

  key_open_a: assert property (
    @(posedge I_REF_CLK) disable iff (I_RST)
    keyed_s |=> key_win == `KEY_WINDOW)
    else $error("key write did not open the window");

endmodule

// *** common/pwm_out_map.svh ***
// Offsets, field positions, reset values and key for the waveform timer
// output and event block. Assumes word-aligned AHB-Lite register access.
`ifndef PWM_OUT_MAP_SVH
`define PWM_OUT_MAP_SVH
// Register indices, byte address is four times the index
`define IDX_CONTROL_REG_C 8'h02
`define IDX_CONTROL_REG_D 8'h03
`define IDX_EVCTRLA 8'h08
`define IDX_EVCTRLB 8'h09
`define IDX_INTEN 8'h0C
`define IDX_INTERRUPT_FLAG_REG 8'h0D
`define IDX_INPUTA 8'h10
`define IDX_INPUTB 8'h11
`define IDX_FAULT_CONTROL_REG 8'h12
`define IDX_DELAY_CONTROL_REG 8'h14
`define IDX_DELAY_VALUE_REG 8'h15
`define IDX_DEBUG_CONTROL_REG 8'h1E
`define IDX_KEY 8'h30
// Field positions
`define B_OVR 0
`define B_SEL_C 6
`define B_SEL_D 7
`define B_ACTION 2
`define B_EDGE 4
`define B_OVF 0
`define B_TRIGGER_FLAG_FIRST 2
`define B_TRIGGER_FLAG_SECOND 3
`define B_DEBUG_RUN_BIT 0
`define B_DEBUG_FAULT_BIT 2
// Reset values
`define RST_BYTE 8'h00
// Key value that opens the protected write window (arbitrary)
`define IO_KEY 8'hA5
`define KEY_WINDOW 3'h4
// Input modes 8 and 9 are edge detected, 1..7 act on both outputs
`define MODE_EDGE_LO 4'h8
`define MODE_EDGE_HI 4'h9
`define MODE_BOTH_HI 4'h7
// Delay select codes
`define DLY_OFF 2'h0
`define DLY_BLANK 2'h1
`define DLY_EVENT 2'h2
`endif

// *** common/pwm_out_pkg.sv ***
// Types shared by the waveform timer output and event block.
// Assumes the map header is compiled with it.
package pwm_out_pkg;
  typedef struct packed {
    logic [3:0] en;
    logic [3:0] val;
  } fault_ctrl_t;
  typedef struct packed {
    logic [1:0] rsv;
    logic [1:0] presc;
    logic [1:0] trig;
    logic [1:0] sel;
  } dly_ctrl_t;
  typedef enum logic {DLY_IDLE, DLY_RUN} dly_state_t;
endpackage

// *** tb/core_model.sv ***
// Behavioural counter core that feeds the output and event block.
// Assumes the block's clock; outputs change just after rising edges.
`timescale 1ns/100ps
module core_model #(
  parameter int PHASE_LEN = 8
) (
  input wire logic i_clk,
  input wire logic i_rst,
  output logic o_wave_first,
  output logic o_wave_second,
  output logic [1:0] o_phase,
  output logic [3:0] o_match,
  output logic o_cycle_done,
  output logic o_mid
);
  int cnt;
  // ---------------------------------------------
  // Phase sequencer
  // ---------------------------------------------
  // Four phases; a compare pulse marks each phase entry, so a window
  // that starts and ends mid-phase never cuts a pulse in half
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      cnt <= 0;
      o_phase <= 2'h0;
      o_match <= 4'h0;
      o_cycle_done <= 1'b0;
    end else begin
      o_match <= 4'h0;
      o_cycle_done <= 1'b0;
      if (cnt == PHASE_LEN - 1) begin
        cnt <= 0;
        o_phase <= o_phase + 2'h1;
        o_match <= 4'h1 << o_phase; // Leaving phase p hits compare p
        o_cycle_done <= (o_phase == 2'h3); // Wrap closes one cycle
      end else begin
        cnt <= cnt + 1;
      end
    end
  end
  // Raw levels: high in the two on phases only
  assign o_wave_first = (o_phase == 2'h1);
  assign o_wave_second = (o_phase == 2'h3);
  assign o_mid = (cnt == PHASE_LEN / 2);
endmodule

// *** tb/testbench.sv ***
// Self-checking bench for the timer output and event block.
// Assumes core_model stands in for the counter core; bus is AHB-Lite.
`timescale 1ns/100ps
`include "pwm_out_map.svh"
module testbench;
  logic ref_clk, rst, hsel, hwrite, one_ramp, sleep, halt, clk_en;
  logic hready, hresp, wf, ws, cdone, mid, prog, irq_ovf, irq_trig;
  logic [31:0] haddr, hwdata, hrdata, rd_cap, r;
  logic [1:0] htrans, ev_in, phase, fault, cap;
  logic [2:0] hsize, mev;
  logic [3:0] match, wave, oe_n;
  int num_errors, samples_checked, dbl;
  int oc[3], ic[3];
  int idx_of[3] = '{3, 0, 2};
  // ---------------------------------------------
  // Design, core model and clock
  // ---------------------------------------------
  pwm_timer_output_event_ctrl #(.DLY_W(8)) dut (.I_REF_CLK(ref_clk),
    .I_RST(rst), .I_CLK_EN(clk_en), .I_HSEL(hsel), .I_HADDR(haddr),
    .I_HTRANS(htrans), .I_HWRITE(hwrite), .I_HSIZE(hsize),
    .I_HWDATA(hwdata), .I_HREADY(hready), .O_HRDATA(hrdata),
    .O_HREADYOUT(hready), .O_HRESP(hresp), .I_WAVE_FIRST(wf),
    .I_WAVE_SECOND(ws), .I_PHASE(phase), .I_ONE_RAMP(one_ramp),
    .I_MATCH(match), .I_CYCLE_DONE(cdone), .I_EVENT_IN(ev_in),
    .I_SLEEP_STOP(sleep), .I_DBG_HALT(halt), .O_WAVE(wave),
    .O_WAVE_OE_N(oe_n), .O_MATCH_EVENT(mev), .O_PROG_EVENT(prog),
    .O_FAULT(fault), .O_CAPTURE(cap), .O_IRQ_OVF(irq_ovf),
    .O_IRQ_TRIG(irq_trig));
  core_model #(.PHASE_LEN(8)) core (.i_clk(ref_clk), .i_rst(rst),
    .o_wave_first(wf), .o_wave_second(ws), .o_phase(phase),
    .o_match(match), .o_cycle_done(cdone), .o_mid(mid));
  initial begin
    ref_clk = 1'b0;
    forever #25 ref_clk = ~ref_clk;
  end
  // ---------------------------------------------
  // Common tasks
  // ---------------------------------------------
  task automatic close_out();
    $display("checks %0d errors %0d", samples_checked, num_errors);
    if (num_errors == 0 && samples_checked > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  task automatic timeout();
    num_errors++;
    $display("MISMATCH wait expected done seen timeout");
    close_out();
  endtask
  task automatic chk(input string what, input logic [31:0] seen,
      input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      num_errors++;
      $display("MISMATCH %s expected %0h seen %0h", what, exp, seen);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(negedge ref_clk);
  endtask
  // Ready and read data are taken at the rising edge, before it updates
  task automatic wait_rdy();
    int n;
    for (n = 0; n < 50; n++) begin
      @(posedge ref_clk);
      rd_cap = hrdata;
      if (hready === 1'b1) break;
    end
    if (n == 50) timeout();
  endtask
  task automatic xfer(input logic wr, input logic [7:0] idx,
      input logic [7:0] wd);
    @(posedge ref_clk);
    hsel <= 1'b1;
    htrans <= 2'h2;
    hwrite <= wr;
    haddr <= {22'h0, idx, 2'b00};
    wait_rdy();
    htrans <= 2'h0;
    hwdata <= {24'h0, wd};
    wait_rdy();
    r = rd_cap;
  endtask
  task automatic wr(input logic [7:0] idx, input logic [7:0] d);
    xfer(1'b1, idx, d);
  endtask
  task automatic wait_mid();
    int n;
    for (n = 0; n < 40; n++) begin
      @(negedge ref_clk);
      if (mid === 1'b1) break;
    end
    if (n == 40) timeout();
  endtask
  // Two core cycles, mid-phase to mid-phase, so no pulse is cut
  task automatic count_ev();
    logic [2:0] prev;
    prev = 3'h0;
    oc = '{0, 0, 0};
    ic = '{0, 0, 0};
    wait_mid();
    repeat (64) begin
      @(negedge ref_clk);
      if ((mev & prev) != 3'h0) dbl++;
      prev = mev;
      for (int k = 0; k < 3; k++) begin
        oc[k] += mev[k];
        ic[k] += match[idx_of[k]];
      end
    end
  endtask
  task automatic set_pin(input int which, input logic v);
    @(posedge ref_clk);
    if (which == 0) halt <= v;
    else if (which == 1) sleep <= v;
    else if (which == 2) ev_in[0] <= v;
    else ev_in[1] <= v;
  endtask
  // Trigger pulse to strobe, in cycles; the strobe must drop again
  task automatic meas(input logic [1:0] t, output int lat);
    int n;
    for (n = 0; n < 40 && match[t] !== 1'b1; n++) @(negedge ref_clk);
    for (lat = 0; lat < 60 && prog !== 1'b1; lat++) @(negedge ref_clk);
    if (n == 40 || lat == 60) timeout();
    @(negedge ref_clk);
    chk("prog_width", prog, 1'b0);
  endtask
  // ---------------------------------------------
  // Scenarios
  // ---------------------------------------------
  task automatic t_regs();
    wr(`IDX_CONTROL_REG_D, 8'h96);
    xfer(1'b0, `IDX_CONTROL_REG_D, 8'h00);
    chk("control_reg_d", r, 32'h96);
    wr(8'h05, 8'h5A);
    xfer(1'b0, 8'h05, 8'h00);
    chk("unmapped", r, 32'h0);
    chk("resp", hresp, 1'b0);
  endtask
  // Fault control takes writes only inside the key window; pin enables follow it
  task automatic t_key();
    logic [7:0] v[2] = '{8'h65, 8'hF5};
    wr(`IDX_FAULT_CONTROL_REG, 8'hF5);
    wr(`IDX_KEY, `IO_KEY);
    repeat (4) xfer(1'b0, `IDX_CONTROL_REG_C, 8'h00);
    wr(`IDX_FAULT_CONTROL_REG, 8'hF5);
    xfer(1'b0, `IDX_FAULT_CONTROL_REG, 8'h00);
    chk("fc_locked", r, 32'h0);
    chk("oe_off", oe_n, 4'hF);
    for (int i = 0; i < 2; i++) begin
      wr(`IDX_KEY, `IO_KEY);
      wr(`IDX_FAULT_CONTROL_REG, v[i]);
      xfer(1'b0, `IDX_FAULT_CONTROL_REG, 8'h00);
      chk("fc_open", r, {24'h0, v[i]});
      cyc(2);
      chk("oe", oe_n, 4'(~v[i][7:4]));
    end
  endtask
  task automatic t_route();
    for (int s = 0; s < 4; s++) begin
      wr(`IDX_CONTROL_REG_C, s[1:0] << 6);
      cyc(1);
      repeat (32) begin
        @(negedge ref_clk);
        chk("aux_one", wave[2], wave[s[0]]);
        chk("aux_two", wave[3], wave[s[1]]);
      end
    end
  endtask
  task automatic t_ovr();
    logic [7:0] d[2] = '{8'h96, 8'h3A};
    for (int m = 0; m < 2; m++) begin
      @(posedge ref_clk);
      one_ramp <= m[0];
      for (int i = 0; i < 2; i++) begin
        wr(`IDX_CONTROL_REG_D, d[i]);
        wr(`IDX_CONTROL_REG_C, 8'h01);
        cyc(1);
        repeat (4) begin
          wait_mid();
          chk("ovr_first", wave[0],
              m ? d[i][phase[0]] : d[i][phase]);
          chk("ovr_second", wave[1],
              m ? d[i][6 + phase[0]] : d[i][4 + phase]);
        end
      end
    end
    @(posedge ref_clk);
    one_ramp <= 1'b0;
    wr(`IDX_CONTROL_REG_C, 8'h00);
  endtask
  task automatic t_match(input string what);
    for (int k = 0; k < 3; k++) chk(what, oc[k], ic[k]);
    chk("double", dbl, 0);
  endtask
  task automatic t_ovf();
    int n;
    wr(`IDX_INTEN, 8'h01);
    for (n = 0; n < 40 && cdone !== 1'b1; n++) @(negedge ref_clk);
    if (n == 40) timeout();
    cyc(3);
    chk("ovf_irq", irq_ovf, 1'b1);
    wr(`IDX_INTERRUPT_FLAG_REG, 8'h01);
    cyc(2);
    chk("ovf_clear", irq_ovf, 1'b0);
    wr(`IDX_INTEN, 8'h00);
    cyc(40);
    chk("ovf_mask", irq_ovf, 1'b0);
    xfer(1'b0, `IDX_INTERRUPT_FLAG_REG, 8'h00);
    chk("ovf_flag", r & 32'h1, 32'h1);
  endtask
  task automatic t_dly();
    int l0[4];
    int l;
    int lb;
    for (int t = 0; t < 4; t++) begin
      wr(`IDX_DELAY_CONTROL_REG, {4'h0, t[1:0], 2'h2});
      wr(`IDX_DELAY_VALUE_REG, 8'h00);
      cyc(40);
      meas(t[1:0], l0[t]);
      chk("delay_zero", l0[t], 2);
    end
    wr(`IDX_DELAY_VALUE_REG, 8'h02);
    for (int p = 0; p < 4; p++) begin
      wr(`IDX_DELAY_CONTROL_REG, {2'h0, p[1:0], 2'h1, 2'h2});
      cyc(40);
      meas(2'h1, l);
      chk("delay", l - l0[1], 2 << p);
    end
    wr(`IDX_DELAY_CONTROL_REG, 8'h05);
    wr(`IDX_DELAY_VALUE_REG, 8'h00);
    cyc(40);
    meas(2'h1, lb);
    wr(`IDX_DELAY_VALUE_REG, 8'h07);
    cyc(40);
    meas(2'h1, l);
    chk("blank_nodelay", l, lb);
  endtask
  task automatic t_fault();
    logic seen;
    seen = 1'b0;
    wr(`IDX_INTEN, 8'h04);
    wr(`IDX_EVCTRLA, 8'h14);
    wr(`IDX_INPUTA, 8'h01);
    set_pin(2, 1'b1);
    repeat (8) begin
      @(negedge ref_clk);
      seen |= cap[0];
    end
    chk("capture", seen, 1'b1);
    chk("fault_a", fault[0], 1'b1);
    chk("fault_wave", wave, 4'h5);
    chk("trig_irq", irq_trig, 1'b1);
    xfer(1'b0, `IDX_INTERRUPT_FLAG_REG, 8'h00);
    chk("trig_a_flag", r & 32'hC, 32'h4);
    set_pin(2, 1'b0);
    cyc(6);
    chk("fault_a_off", fault[0], 1'b0);
    wr(`IDX_INPUTA, 8'h00);
    wr(`IDX_INTERRUPT_FLAG_REG, 8'h04);
    cyc(2);
    chk("trig_clear", irq_trig, 1'b0);
    wr(`IDX_INTEN, 8'h00);
    wr(`IDX_EVCTRLB, 8'h10);
    set_pin(3, 1'b1);
    cyc(2);
    set_pin(3, 1'b0);
    cyc(6);
    chk("trig_mask", irq_trig, 1'b0);
    wr(`IDX_INTEN, 8'h08);
    cyc(2);
    chk("trig_b_irq", irq_trig, 1'b1);
    wr(`IDX_INTERRUPT_FLAG_REG, 8'h08);
    cyc(2);
    chk("trig_b_clear", irq_trig, 1'b0);
  endtask
  // Edge modes act once per edge, level modes for as long as it is held
  task automatic t_edge();
    logic [3:0] md[3] = '{4'h1, `MODE_EDGE_LO, `MODE_EDGE_HI};
    int cnt;
    for (int i = 0; i < 3; i++) begin
      wr(`IDX_INPUTB, {4'h0, md[i]});
      set_pin(3, 1'b1);
      cnt = 0;
      repeat (16) begin
        @(negedge ref_clk);
        cnt += fault[1];
      end
      chk("edge_level", cnt == 1, i > 0);
      set_pin(3, 1'b0);
      cyc(6);
    end
    wr(`IDX_INPUTB, 8'h00);
  endtask
  task automatic t_stop();
    wr(`IDX_DEBUG_CONTROL_REG, 8'h00);
    for (int w = 0; w < 2; w++) begin
      set_pin(w, 1'b1);
      count_ev();
      chk("stopped", oc[0] + oc[1] + oc[2], 0);
      set_pin(w, 1'b0);
    end
    wr(`IDX_DEBUG_CONTROL_REG, 8'h01);
    set_pin(0, 1'b1);
    count_ev();
    t_match("debug_run");
    set_pin(0, 1'b0);
    wr(`IDX_DEBUG_CONTROL_REG, 8'h04);
    set_pin(0, 1'b1);
    cyc(8);
    chk("debug_fault", fault, 2'h3);
    set_pin(0, 1'b0);
    wr(`IDX_DEBUG_CONTROL_REG, 8'h00);
    cyc(8);
    chk("debug_fault_off", fault, 2'h0);
  endtask
  // ---------------------------------------------
  // Main sequence
  // ---------------------------------------------
  initial begin
    {rst, clk_en} = 2'b11;
    {hsel, hwrite, one_ramp, sleep, halt} = 5'h0;
    {haddr, hwdata, htrans, ev_in, hsize} = {64'h0, 4'h0, 3'h2};
    {num_errors, samples_checked, dbl} = {32'h0, 32'h0, 32'h0};
    repeat (15) @(posedge ref_clk);
    @(negedge ref_clk);
    chk("oe_reset", oe_n, 4'hF);
    chk("ready_reset", hready, 1'b0);
    @(posedge ref_clk);
    rst <= 1'b0;
    t_regs();
    t_key();
    t_route();
    t_ovr();
    count_ev();
    t_match("match_run");
    t_ovf();
    t_dly();
    t_fault();
    t_edge();
    t_stop();
    close_out();
  end
endmodule
